// ---- logic/can_mode_regs.svh ----
// Timing counts and sizes for the CAN mode control block.
`ifndef CAN_MODE_REGS_SVH
`define CAN_MODE_REGS_SVH
`define CAN_CLK_PERIOD_PS 5000
`define CAN_BIT_TIME_NS 1000
`define CAN_BIT_CYCLES ((`CAN_BIT_TIME_NS * 1000) / `CAN_CLK_PERIOD_PS)
`define CAN_IDLE_BITS 4'hB
`define CAN_MAILBOXES 3
`define CAN_FILTER_BANKS 14
`define CAN_FIFO_DEPTH 3
`define CAN_RX_FIFOS 2
`define CAN_RECESSIVE 1'h1
`endif

// ---- logic/can_mode_pkg.sv ----
// Types shared by the CAN mode control block.
package can_mode_pkg;
   typedef enum logic [1:0] {
      MODE_SLEEP = 2'h0,
      MODE_INIT = 2'h1,
      MODE_SYNC = 2'h3,
      MODE_NORMAL = 2'h2
   } mode_t;
   typedef struct packed {
      logic silent;
      logic loopback;
   } test_mode_t;
   typedef struct packed {
      logic wr;
      logic init_req;
      logic sleep_req;
   } ctrl_write_t;
   typedef struct packed {
      logic [28:0] id;
      logic [3:0] dlc;
      logic [63:0] data;
      logic [3:0] bank;
   } rx_msg_t;
endpackage

// ---- logic/can_mode_control.sv ----
// Mode control, test mode routing, transmit scheduling and receive queues.
//
// What this block does
// - Eleven recessive bits mean bus idle, synchronized.
// - Reset enters sleep with transmit pull-up on.
// - Acknowledged init or sleep after the first control write turns pull-up off.
// - Normal mode exactly when both acks low.
// - Init request without sleep sets init ack.
// - Init mode: no traffic, transmit pin recessive.
// - Init ack clears after exit and bus sync, or at once on entry to sleep.
// - Filter init blocks all reception.
// - Sleep request without init request sets sleep ack.
// - Sleep stops kernel clock, mailboxes stay reachable.
// - Auto wake-up clears sleep request on activity.
// - Bus activity in sleep raises wake-up interrupt.
// - Sleep ack clears after bus sync, or at once on entry to init.
// - Test mode chosen in init, applied on exit.
// - Loopback feeds transmit to receive internally.
// - Silent mode drives only recessive bits.
// - Loopback-silent isolates both pins.
// - Three mailboxes scheduled by identifier or order.
// - Two three-deep queues fed by 14 banks.
`timescale 1ns/1ps
`include "can_mode_regs.svh"
module can_mode_control #(
   parameter int BIT_CYCLES = `CAN_BIT_CYCLES,
   parameter int NUM_MB = `CAN_MAILBOXES,
   parameter int NUM_BANKS = `CAN_FILTER_BANKS,
   parameter int DEPTH = `CAN_FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire can_mode_pkg::ctrl_write_t ctrl_write,
   input wire logic auto_wakeup_enable,
   input wire logic wakeup_irq_enable,
   input wire logic silent_select,
   input wire logic loopback_select,
   input wire logic filter_init_control,
   output logic init_request,
   output logic sleep_request,
   output logic init_ack,
   output logic sleep_ack,
   output logic wakeup_irq,
   output logic tx_pullup_en,
   output logic kernel_clk_en,
   output logic rx_enable,
   output logic tx_enable,
   output logic bus_idle,
   input wire logic bus_rx_pin,
   output logic bus_tx_pin,
   input wire logic core_tx,
   output logic core_rx,
   input wire logic [NUM_MB-1:0] tx_pending,
   input wire logic [28:0] tx_id [NUM_MB],
   input wire logic tx_fifo_prio,
   output logic [1:0] tx_select,
   output logic tx_select_valid,
   input wire logic rx_msg_valid,
   input wire can_mode_pkg::rx_msg_t rx_msg,
   input wire logic [NUM_BANKS-1:0] filter_match,
   input wire logic [NUM_BANKS-1:0] filter_bank_active,
   input wire logic [NUM_BANKS-1:0] filter_fifo_assign,
   input wire logic [1:0] fifo_lock,
   input wire logic [1:0] fifo_release,
   output logic [1:0] fifo_level [2],
   output can_mode_pkg::rx_msg_t fifo_head [2],
   output logic [1:0] fifo_overrun
);
   ////////////////////////////////////////////////////////////////////////
   can_mode_pkg::mode_t mode, next_mode;
   can_mode_pkg::test_mode_t test_mode, next_test_mode;
   logic next_init_request, next_sleep_request, next_pullup, next_wakeup_irq;
   logic requested, next_requested, from_sleep, next_from_sleep;
   logic rx_prev, wake_edge, running, next_bus_tx_pin;
   logic [15:0] bit_cnt, next_bit_cnt;
   logic [3:0] rec_cnt, next_rec_cnt;

   assign running = (mode == can_mode_pkg::MODE_SYNC) ||
                    (mode == can_mode_pkg::MODE_NORMAL);
   assign wake_edge = (mode == can_mode_pkg::MODE_SLEEP) && rx_prev &&
                      !bus_rx_pin;
   assign init_ack = (mode == can_mode_pkg::MODE_INIT) ||
                     ((mode == can_mode_pkg::MODE_SYNC) && !from_sleep);
   assign sleep_ack = (mode == can_mode_pkg::MODE_SLEEP) ||
                      ((mode == can_mode_pkg::MODE_SYNC) && from_sleep);
   assign kernel_clk_en = (mode != can_mode_pkg::MODE_SLEEP);
   assign tx_enable = (mode == can_mode_pkg::MODE_NORMAL);
   assign rx_enable = tx_enable && !filter_init_control;
   assign bus_idle = (rec_cnt == `CAN_IDLE_BITS);

   always_comb begin
      core_rx = bus_rx_pin;
      if (running && test_mode.loopback) begin
         core_rx = core_tx;
      end else if (running && test_mode.silent) begin
         core_rx = bus_rx_pin & core_tx;
      end
   end

   always_comb begin
      next_mode = mode;
      next_test_mode = test_mode;
      next_init_request = init_request;
      next_sleep_request = sleep_request;
      next_requested = requested;
      next_from_sleep = from_sleep;
      next_pullup = tx_pullup_en;
      next_wakeup_irq = wake_edge && wakeup_irq_enable;
      if (ctrl_write.wr) begin
         next_init_request = ctrl_write.init_req;
         next_sleep_request = ctrl_write.sleep_req;
         next_requested = 1'h1;
      end
      if (wake_edge && auto_wakeup_enable &&
          !(ctrl_write.wr && ctrl_write.sleep_req)) begin
         next_sleep_request = 1'h0;
      end
      case (mode)
         can_mode_pkg::MODE_SLEEP: begin
            if (init_request && !sleep_request) begin
               next_mode = can_mode_pkg::MODE_INIT;
            end else if (!sleep_request) begin
               next_mode = can_mode_pkg::MODE_SYNC;
               next_from_sleep = 1'h1;
            end
         end
         can_mode_pkg::MODE_INIT: begin
            next_test_mode = '{silent: silent_select,
                               loopback: loopback_select};
            if (!init_request && sleep_request) begin
               next_mode = can_mode_pkg::MODE_SLEEP;
            end else if (!init_request) begin
               next_mode = can_mode_pkg::MODE_SYNC;
               next_from_sleep = 1'h0;
            end
         end
         default: begin
            if (init_request) begin
               next_mode = can_mode_pkg::MODE_INIT;
            end else if (sleep_request) begin
               next_mode = can_mode_pkg::MODE_SLEEP;
            end else if (mode == can_mode_pkg::MODE_SYNC && bus_idle) begin
               next_mode = can_mode_pkg::MODE_NORMAL;
            end
         end
      endcase
      if (requested && !running) begin
         next_pullup = 1'h0;
      end
      next_bus_tx_pin = `CAN_RECESSIVE;
      if (running && !test_mode.silent) begin
         next_bus_tx_pin = core_tx;
      end
      next_bit_cnt = bit_cnt + 16'h0_001;
      next_rec_cnt = rec_cnt;
      if (mode == can_mode_pkg::MODE_SLEEP) begin
         next_bit_cnt = 16'h0_000;
         next_rec_cnt = 4'h0;
      end else if (bit_cnt == 16'(BIT_CYCLES - 1)) begin
         next_bit_cnt = 16'h0_000;
         if (!core_rx) begin
            next_rec_cnt = 4'h0;
         end else if (!bus_idle) begin
            next_rec_cnt = rec_cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode <= can_mode_pkg::MODE_SLEEP;
         test_mode <= '0;
         init_request <= 1'h0;
         sleep_request <= 1'h1;
         requested <= 1'h0;
         from_sleep <= 1'h1;
         tx_pullup_en <= 1'h1;
         wakeup_irq <= 1'h0;
         rx_prev <= `CAN_RECESSIVE;
         bus_tx_pin <= `CAN_RECESSIVE;
         bit_cnt <= 16'h0_000;
         rec_cnt <= 4'h0;
      end else begin
         mode <= next_mode;
         test_mode <= next_test_mode;
         init_request <= next_init_request;
         sleep_request <= next_sleep_request;
         requested <= next_requested;
         from_sleep <= next_from_sleep;
         tx_pullup_en <= next_pullup;
         wakeup_irq <= next_wakeup_irq;
         rx_prev <= bus_rx_pin;
         bus_tx_pin <= next_bus_tx_pin;
         bit_cnt <= next_bit_cnt;
         rec_cnt <= next_rec_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [1:0] rank [NUM_MB];
   logic [1:0] next_rank [NUM_MB];
   logic [NUM_MB-1:0] pend_prev;
   logic [1:0] next_tx_select;
   logic next_tx_select_valid;

   always_comb begin
      logic [1:0] stay;
      logic [1:0] dec;
      stay = 2'h0;
      dec = 2'h0;
      next_tx_select = 2'h0;
      next_tx_select_valid = 1'h0;
      for (int j = 0; j < NUM_MB; j++) begin
         stay = stay + 2'(pend_prev[j] & tx_pending[j]);
      end
      for (int j = 0; j < NUM_MB; j++) begin
         dec = 2'h0;
         for (int i = 0; i < NUM_MB; i++) begin
            if (pend_prev[i] && !tx_pending[i] && rank[i] < rank[j]) begin
               dec = dec + 2'h1;
            end
         end
         next_rank[j] = rank[j] - dec;
         if (tx_pending[j] && !pend_prev[j]) begin
            next_rank[j] = stay;
            stay = stay + 2'h1;
         end
      end
      for (int j = 0; j < NUM_MB; j++) begin
         if (tx_pending[j] && (!next_tx_select_valid ||
             (tx_fifo_prio ? next_rank[j] < next_rank[next_tx_select]
                           : tx_id[j] < tx_id[next_tx_select]))) begin
            next_tx_select = 2'(j);
            next_tx_select_valid = 1'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rank <= '{default: 2'h0};
         pend_prev <= '0;
         tx_select <= 2'h0;
         tx_select_valid <= 1'h0;
      end else begin
         rank <= next_rank;
         pend_prev <= tx_pending;
         tx_select <= next_tx_select;
         tx_select_valid <= next_tx_select_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   can_mode_pkg::rx_msg_t mem [2][DEPTH];
   can_mode_pkg::rx_msg_t next_mem [2][DEPTH];
   logic [1:0] next_level [2];
   logic [1:0] next_overrun;

   always_comb begin
      logic hit;
      logic target;
      can_mode_pkg::rx_msg_t msg;
      hit = 1'h0;
      target = 1'h0;
      msg = rx_msg;
      next_mem = mem;
      next_level = fifo_level;
      next_overrun = 2'h0;
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (!hit && filter_match[b] && filter_bank_active[b]) begin
            hit = 1'h1;
            target = filter_fifo_assign[b];
            msg.bank = 4'(b);
         end
      end
      for (int f = 0; f < 2; f++) begin
         if (fifo_release[f] && fifo_level[f] != 2'h0) begin
            for (int k = 0; k < DEPTH - 1; k++) begin
               next_mem[f][k] = mem[f][k+1];
            end
            next_level[f] = fifo_level[f] - 2'h1;
         end
         if (rx_msg_valid && rx_enable && hit && target == 1'(f)) begin
            if (next_level[f] < 2'(DEPTH)) begin
               next_mem[f][next_level[f]] = msg;
               next_level[f] = next_level[f] + 2'h1;
            end else begin
               next_overrun[f] = 1'h1;
               if (!fifo_lock[f]) begin
                  next_mem[f][DEPTH-1] = msg;
               end
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mem <= '{default: '{default: '0}};
         fifo_level <= '{default: 2'h0};
         fifo_overrun <= 2'h0;
      end else begin
         mem <= next_mem;
         fifo_level <= next_level;
         fifo_overrun <= next_overrun;
      end
   end

   assign fifo_head[0] = mem[0][0];
   assign fifo_head[1] = mem[1][0];

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_wake;
      wake_edge && auto_wakeup_enable && !ctrl_write.wr;
   endsequence
   sequence s_init_write;
      ctrl_write.wr && ctrl_write.init_req && !ctrl_write.sleep_req;
   endsequence

   AST_IDLE_BEFORE_NORMAL: assert property (
      $rose(mode == can_mode_pkg::MODE_NORMAL) |-> $past(bus_idle))
      else $error("Normal mode entered without bus idle.");
   AST_PULLUP_UNTIL_REQ: assert property (
      !requested |-> tx_pullup_en)
      else $error("Pull-up dropped before any request.");
   AST_PULLUP_OFF: assert property (
      requested && init_ack && mode == can_mode_pkg::MODE_INIT
      |=> !tx_pullup_en)
      else $error("Pull-up still on after acknowledged init.");
   AST_NORMAL_ACKS: assert property (
      (mode == can_mode_pkg::MODE_NORMAL) == (!init_ack && !sleep_ack))
      else $error("Normal mode and acknowledge flags disagree.");
   AST_INIT_ENTRY: assert property (
      s_init_write ##1 (mode != can_mode_pkg::MODE_SLEEP) |=> init_ack)
      else $error("Init acknowledge missing after request.");
   AST_INIT_RECESSIVE: assert property (
      mode == can_mode_pkg::MODE_INIT |=> bus_tx_pin && !tx_enable)
      else $error("Transmit pin not recessive in init.");
   AST_INIT_EXIT_SYNC: assert property (
      $fell(init_ack) |-> $past(bus_idle) || $past(sleep_request))
      else $error("Init acknowledge cleared before sync.");
   AST_FILTER_BLOCK: assert property (
      filter_init_control |-> !rx_enable)
      else $error("Reception enabled during filter init.");
   AST_CLK_STOP: assert property (
      mode == can_mode_pkg::MODE_SLEEP |-> !kernel_clk_en && sleep_ack)
      else $error("Kernel clock running in sleep.");
   AST_AUTO_WAKE: assert property (
      s_wake |=> !sleep_request ##1 (mode != can_mode_pkg::MODE_SLEEP))
      else $error("Sleep request not cleared on bus activity.");
   AST_WAKE_IRQ: assert property (
      wake_edge && wakeup_irq_enable |=> wakeup_irq)
      else $error("Wake-up interrupt missing.");
   AST_SLEEP_EXIT_SYNC: assert property (
      $fell(sleep_ack) && mode == can_mode_pkg::MODE_NORMAL
      |-> $past(bus_idle))
      else $error("Sleep acknowledge cleared before sync.");
   AST_LOOP_RX: assert property (
      running && test_mode.loopback |-> core_rx == core_tx)
      else $error("Loopback receive does not follow transmit.");
   AST_SILENT_TX: assert property (
      running && test_mode.silent |=> bus_tx_pin)
      else $error("Silent mode drove a dominant bit.");
   AST_FIFO_BOUND: assert property (
      fifo_level[0] <= 2'(DEPTH) && fifo_level[1] <= 2'(DEPTH))
      else $error("Receive queue level beyond depth.");
endmodule // can_mode_control

// ---- verification/can_bus_partner.sv ----
// Bus transceiver and remote node model for the CAN mode bench.
`timescale 1ns/1ps
module can_bus_partner (
   input wire logic bus_tx_pin,
   input wire logic remote_dominant,
   output logic bus_rx_pin
);
   // Wired-and bus with pull-up: any dominant driver wins.
   assign bus_rx_pin = bus_tx_pin & ~remote_dominant;
endmodule // can_bus_partner

// ---- verification/can_mode_control_tb.sv ----
// Self-checking bench for the CAN mode control block.
`timescale 1ns/1ps
module can_mode_control_tb;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   can_mode_pkg::ctrl_write_t ctrl_write = '0;
   logic auto_wakeup_enable = 1'b0;
   logic wakeup_irq_enable = 1'b0;
   logic silent_select = 1'b0;
   logic loopback_select = 1'b0;
   logic filter_init_control = 1'b0;
   logic core_tx = 1'b1;
   logic remote_dominant = 1'b0;
   logic tx_fifo_prio = 1'b0;
   logic rx_msg_valid = 1'b0;
   logic [2:0] tx_pending = '0;
   logic [28:0] tx_id [3];
   can_mode_pkg::rx_msg_t rx_msg = '0;
   logic [13:0] filter_match = '0;
   logic [13:0] filter_bank_active = '0;
   logic [13:0] filter_fifo_assign = '0;
   logic [1:0] fifo_lock = '0;
   logic [1:0] fifo_release = '0;
   logic init_request, sleep_request, init_ack, sleep_ack, wakeup_irq;
   logic tx_pullup_en, kernel_clk_en, rx_enable, tx_enable, bus_idle;
   logic bus_rx_pin, bus_tx_pin, core_rx, tx_select_valid;
   logic [1:0] tx_select;
   logic [1:0] fifo_overrun;
   logic [1:0] fifo_level [2];
   can_mode_pkg::rx_msg_t fifo_head [2];
   logic [1:0] wake_count = '0;
   logic seen_ovr = 1'b0;
   int num_errors = 0;
   int tests_run = 0;

   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (wakeup_irq === 1'b1) wake_count <= wake_count + 2'h1;
      if (fifo_overrun[0] === 1'b1) seen_ovr <= 1'b1;
   end

   can_mode_control #(.BIT_CYCLES(4)) i_dut (
      .core_clk(core_clk), .reset_n(reset_n), .ctrl_write(ctrl_write),
      .auto_wakeup_enable(auto_wakeup_enable),
      .wakeup_irq_enable(wakeup_irq_enable),
      .silent_select(silent_select), .loopback_select(loopback_select),
      .filter_init_control(filter_init_control),
      .init_request(init_request), .sleep_request(sleep_request),
      .init_ack(init_ack), .sleep_ack(sleep_ack), .wakeup_irq(wakeup_irq),
      .tx_pullup_en(tx_pullup_en), .kernel_clk_en(kernel_clk_en),
      .rx_enable(rx_enable), .tx_enable(tx_enable), .bus_idle(bus_idle),
      .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin),
      .core_tx(core_tx), .core_rx(core_rx), .tx_pending(tx_pending),
      .tx_id(tx_id), .tx_fifo_prio(tx_fifo_prio), .tx_select(tx_select),
      .tx_select_valid(tx_select_valid), .rx_msg_valid(rx_msg_valid),
      .rx_msg(rx_msg), .filter_match(filter_match),
      .filter_bank_active(filter_bank_active),
      .filter_fifo_assign(filter_fifo_assign), .fifo_lock(fifo_lock),
      .fifo_release(fifo_release), .fifo_level(fifo_level),
      .fifo_head(fifo_head), .fifo_overrun(fifo_overrun)
   );
   can_bus_partner i_partner (
      .bus_tx_pin(bus_tx_pin), .remote_dominant(remote_dominant),
      .bus_rx_pin(bus_rx_pin)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("Errors %0d in %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [1:0] seen, input logic [1:0] exp,
                        input string what);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s saw %0h expected %0h",
                  $time, what, seen, exp);
      end
   endtask

   task automatic check1(input logic seen, input logic exp, input string what);
      check({1'b0, seen}, {1'b0, exp}, what);
   endtask

   task automatic write_ctrl(input logic init, input logic sleep);
      @(negedge core_clk);
      ctrl_write = '{wr: 1'b1, init_req: init, sleep_req: sleep};
      @(negedge core_clk);
      ctrl_write.wr = 1'b0;
   endtask

   task automatic wait_ack(input logic sel_sleep, input logic val,
                           input int limit);
      int n;
      n = 0;
      while (((sel_sleep ? sleep_ack : init_ack) !== val) && n < limit) begin
         @(negedge core_clk);
         n++;
      end
      check1(sel_sleep ? sleep_ack : init_ack, val, "ack wait");
   endtask

   task automatic send_msg(input logic [1:0] id);
      @(negedge core_clk);
      rx_msg.id = {27'h0, id};
      rx_msg_valid = 1'b1;
      @(negedge core_clk);
      rx_msg_valid = 1'b0;
      @(negedge core_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      end_of_test();
   end

   initial begin
      tx_id = '{29'h5, 29'h3, 29'h3};
      repeat (10) @(negedge core_clk);
      reset_n = 1'b1;
      check1(sleep_ack, 1'b1, "reset sleep ack");
      check1(init_ack, 1'b0, "reset init ack");
      check1(tx_pullup_en, 1'b1, "reset pull-up");
      check1(kernel_clk_en, 1'b0, "sleep clock");
      write_ctrl(1'b1, 1'b0);
      wait_ack(1'b0, 1'b1, 4);
      check1(sleep_ack, 1'b0, "init leaves sleep");
      @(negedge core_clk);
      check1(tx_pullup_en, 1'b0, "init pull-up");
      core_tx = 1'b0;
      repeat (2) @(negedge core_clk);
      check1(bus_tx_pin, 1'b1, "init recessive");
      check1(rx_enable | tx_enable, 1'b0, "init no traffic");
      core_tx = 1'b1;
      for (int m = 0; m < 4; m++) begin
         silent_select = m[0];
         loopback_select = m[1];
         remote_dominant = 1'b1;
         repeat (5) @(negedge core_clk);
         remote_dominant = 1'b0;
         write_ctrl(1'b0, 1'b0);
         repeat (20) @(negedge core_clk);
         check1(init_ack, 1'b1, "ack held until sync");
         wait_ack(1'b0, 1'b0, 100);
         check1(bus_idle, 1'b1, "bus idle");
         check1(rx_enable, 1'b1, "normal mode");
         core_tx = 1'b0;
         repeat (2) @(negedge core_clk);
         check1(bus_tx_pin, m[0], "pin drive");
         core_tx = 1'b1;
         remote_dominant = 1'b1;
         repeat (2) @(negedge core_clk);
         check1(core_rx, m[1], "receive path");
         remote_dominant = 1'b0;
         write_ctrl(1'b1, 1'b0);
         wait_ack(1'b0, 1'b1, 4);
      end
      silent_select = 1'b0;
      loopback_select = 1'b0;
      write_ctrl(1'b0, 1'b0);
      wait_ack(1'b0, 1'b0, 100);
      filter_init_control = 1'b1;
      @(negedge core_clk);
      filter_bank_active = 14'h0003;
      filter_match = 14'h0003;
      filter_fifo_assign = 14'h0002;
      send_msg(2'h0);
      check1(rx_enable, 1'b0, "filter init blocks");
      check(fifo_level[0] | fifo_level[1], 2'h0, "nothing stored");
      filter_init_control = 1'b0;
      for (int k = 1; k <= 4; k++) begin
         send_msg(k[1:0]);
         check(fifo_level[0], (k > 3) ? 2'h3 : k[1:0], "fifo level");
      end
      check1(seen_ovr, 1'b1, "overrun");
      check(fifo_level[1], 2'h0, "lowest bank fifo");
      check(fifo_head[0].id[1:0], 2'h1, "fifo head");
      @(negedge core_clk);
      fifo_release = 2'h1;
      @(negedge core_clk);
      fifo_release = 2'h0;
      @(negedge core_clk);
      check(fifo_level[0], 2'h2, "release");
      fifo_lock = 2'h1;
      send_msg(2'h1);
      send_msg(2'h3);
      check(fifo_level[0], 2'h3, "locked level");
      repeat (2) begin
         fifo_release = 2'h1;
         @(negedge core_clk);
      end
      fifo_release = 2'h0;
      @(negedge core_clk);
      check(fifo_head[0].id[1:0], 2'h1, "lock discards");
      tx_pending = 3'h7;
      repeat (2) @(negedge core_clk);
      check(tx_select, 2'h1, "lowest id wins");
      tx_fifo_prio = 1'b1;
      tx_pending = 3'h0;
      repeat (2) @(negedge core_clk);
      tx_pending = 3'h4;
      repeat (2) @(negedge core_clk);
      tx_pending = 3'h5;
      repeat (2) @(negedge core_clk);
      check(tx_select, 2'h2, "request order");
      check1(tx_select_valid, 1'b1, "select valid");
      write_ctrl(1'b0, 1'b1);
      wait_ack(1'b1, 1'b1, 4);
      @(negedge core_clk);
      check1(kernel_clk_en, 1'b0, "sleep clock");
      check1(tx_pullup_en, 1'b0, "sleep pull-up");
      wakeup_irq_enable = 1'b1;
      auto_wakeup_enable = 1'b1;
      remote_dominant = 1'b1;
      repeat (3) @(negedge core_clk);
      check(wake_count, 2'h1, "wake irq");
      check1(sleep_request, 1'b0, "auto wake");
      check1(sleep_ack, 1'b1, "ack held until sync");
      remote_dominant = 1'b0;
      wait_ack(1'b1, 1'b0, 100);
      auto_wakeup_enable = 1'b0;
      write_ctrl(1'b0, 1'b1);
      wait_ack(1'b1, 1'b1, 4);
      write_ctrl(1'b1, 1'b1);
      repeat (3) @(negedge core_clk);
      check1(init_request, 1'b1, "init request held");
      check1(init_ack, 1'b0, "combined write refused");
      remote_dominant = 1'b1;
      repeat (3) @(negedge core_clk);
      check(wake_count, 2'h2, "wake irq manual");
      check1(sleep_request, 1'b1, "no auto wake");
      remote_dominant = 1'b0;
      write_ctrl(1'b0, 1'b0);
      wait_ack(1'b1, 1'b0, 100);
      end_of_test();
   end
endmodule // can_mode_control_tb
